/* File: rtl/pitp_pkg.sv */
/*
  shared constants, carriers and arithmetic for the interval timer host port.
  assumes a single 200 MHz system clock; pin inputs are synchronised inside the host port and counters.
*/
package pitp_pkg;

  // ==========================================================================
  // geometry and timing
  localparam int PITP_NUM_CH = 3;
  localparam int PITP_CNT_W = 16;
  localparam int PITP_SYNC_STAGES = 2;
  localparam int PITP_CLK_PERIOD_NS = 5;

  // ==========================================================================
  // port addresses and control word layout
  localparam logic [1:0] PITP_ADDR_CTRL = 2'h3;
  localparam int PITP_SC_HI = 7;
  localparam int PITP_SC_LO = 6;
  localparam int PITP_RL_HI = 5;
  localparam int PITP_RL_LO = 4;
  localparam int PITP_MODE_HI = 3;
  localparam int PITP_MODE_LO = 1;
  localparam int PITP_BCD_BIT = 0;
  localparam int PITP_MODE_PERIODIC_BIT = 1;
  localparam logic [1:0] PITP_SC_ILLEGAL = 2'h3;
  localparam logic [1:0] PITP_RL_LATCH = 2'h0;
  localparam logic [1:0] PITP_RL_LSB = 2'h1;
  localparam logic [1:0] PITP_RL_MSB = 2'h2;
  localparam logic [1:0] PITP_RL_BOTH = 2'h3;
  localparam logic [7:0] PITP_BYTE_ZERO = 8'h00;
  localparam logic [15:0] PITP_CNT_ONE = 16'h0001;
  localparam logic [15:0] PITP_CNT_ZERO = 16'h0000;
  localparam logic [15:0] PITP_BCD_MAX = 16'h9999;
  localparam logic [3:0] PITP_DIGIT_NINE = 4'h9;

  // ==========================================================================
  // carriers
  typedef enum logic {
    PITP_PH_LSB = 1'b0,
    PITP_PH_MSB = 1'b1
  } pitp_phase_t;

  typedef struct packed {
    logic [1:0] rl;
    logic [2:0] mode;
    logic bcd;
  } pitp_cfg_t;

  localparam pitp_cfg_t PITP_CFG_RST = 6'h00;

  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [1:0] addr;
    logic [7:0] data;
  } pitp_bus_t;

  localparam pitp_bus_t PITP_BUS_IDLE = 13'h1C00;

  typedef struct packed {
    logic [1:0] tsync;
    logic [1:0] gsync;
    logic tprev;
    logic pend;
    logic armed;
    logic [15:0] reload;
    logic [15:0] count;
    logic out;
  } pitp_cnt_st_t;

  // ==========================================================================
  // down count by one, binary or four bcd decades
  function automatic logic [15:0] pitp_dec(input logic [15:0] v,
                                           input logic bcd);
    logic [15:0] r;
    logic borrow;
    r = v;
    borrow = 1'b1;
    if (!bcd) begin
      r = v - PITP_CNT_ONE;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (borrow) begin
          if (v[4*i +: 4] == 4'h0) begin
            r[4*i +: 4] = PITP_DIGIT_NINE;
          end else begin
            r[4*i +: 4] = v[4*i +: 4] - 4'h1;
            borrow = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction

  // address to channel index, control address folds to channel 0
  function automatic logic [1:0] pitp_chan(input logic [1:0] a);
    return (a == PITP_ADDR_CTRL) ? 2'h0 : a;
  endfunction

endpackage

/* File: rtl/pitp_counter.sv */
/*
  one 16-bit presettable down counter with its own clock and gate pins.
  assumes load requests are single-cycle pulses from the host port logic.
*/
`timescale 1ns/1ps
module pitp_counter
  import pitp_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic tclk, // counter clock pin
  input wire logic gate, // gate pin
  input wire logic load_req, // new count pulse
  input wire logic [15:0] load_val, // new count value
  input wire logic bcd, // decimal counting
  input wire logic [2:0] mode, // operating mode
  output logic [15:0] count, // current count
  output logic out // counter output
);

  // ==========================================================================
  // state
  pitp_cnt_st_t st;
  pitp_cnt_st_t next_st;
  logic rise;
  logic fall;
  logic periodic;
  logic [15:0] dec;

  assign rise = st.tsync[1] & ~st.tprev;
  assign fall = ~st.tsync[1] & st.tprev;
  assign periodic = mode[PITP_MODE_PERIODIC_BIT];
  assign dec = pitp_dec(st.count, bcd);

  always_comb begin
    next_st = st;
    next_st.tsync = {st.tsync[0], tclk};
    next_st.gsync = {st.gsync[0], gate};
    next_st.tprev = st.tsync[1];
    if (load_req) begin
      next_st.pend = 1'b1;
      next_st.armed = 1'b0;
      next_st.reload = load_val;
    end else if (st.pend) begin
      if (rise) begin
        next_st.armed = 1'b1;
      end
      if (fall && st.armed) begin
        next_st.count = st.reload;
        next_st.pend = 1'b0;
        next_st.out = periodic;
      end
    end else if (fall && st.gsync[1]) begin
      // counting runs on its own pins only
      if (periodic && st.count == PITP_CNT_ONE) begin
        next_st.count = st.reload;
        next_st.out = 1'b0;
      end else begin
        next_st.count = dec;
        next_st.out = periodic ? 1'b1 : (st.out | (dec == PITP_CNT_ZERO));
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign count = st.count;
  assign out = st.out;

  // ==========================================================================
  // checks
  chk_load_wait: assert property (@(posedge clk) disable iff (!rst_n)
    st.pend && !(fall && st.armed) && !load_req |=> $stable(st.count))
    else $error("count changed before load edges");

  chk_load_take: assert property (@(posedge clk) disable iff (!rst_n)
    st.pend && st.armed && fall && !load_req |=>
      st.count == $past(st.reload))
    else $error("pending count not taken");

  chk_bin_step: assert property (@(posedge clk) disable iff (!rst_n)
    !st.pend && !load_req && fall && st.gsync[1] && !bcd && !periodic
      |=> st.count == $past(st.count) - PITP_CNT_ONE)
    else $error("binary count did not step by one");

  chk_bcd_wrap: assert property (@(posedge clk) disable iff (!rst_n)
    !st.pend && !load_req && fall && st.gsync[1] && bcd && !periodic &&
      st.count == PITP_CNT_ZERO |=> st.count == PITP_BCD_MAX)
    else $error("decimal count did not wrap to 9999");

  cov_load: cover property (@(posedge clk) disable iff (!rst_n)
    st.pend ##1 !st.pend);

endmodule

/* File: rtl/pitp_host_port.sv */
/*
  host port of a three-channel interval timer: bus buffer, read/write
  decode, control word store, byte sequencing and count readback.
  assumes a cpu bus on pins, asynchronous to clk; counter clocks and gates
  are pins too and are synchronised inside each counter.
*/
`timescale 1ns/1ps
module pitp_host_port
  import pitp_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic cs_n, // device select, active low
  input wire logic rd_n, // read strobe, active low
  input wire logic wr_n, // write strobe, active low
  input wire logic port_addr_low, // address bit 0
  input wire logic port_addr_high, // address bit 1
  input wire logic [7:0] data_in, // data pins in
  output logic [7:0] data_out, // data pins out
  output logic data_oe, // data pins driven
  input wire logic [2:0] tmr_clk, // counter clock pins
  input wire logic [2:0] tmr_gate, // counter gate pins
  output logic [2:0] tmr_out // counter outputs
);

  // ==========================================================================
  // state
  typedef struct packed {
    pitp_bus_t s1;
    pitp_bus_t s2;
    pitp_bus_t s3;
    pitp_cfg_t [2:0] cfg;
    pitp_phase_t [2:0] wr_ph;
    pitp_phase_t [2:0] rd_ph;
    logic [2:0][7:0] lsb_hold;
    logic [2:0] latched;
    logic [2:0][15:0] latch_val;
    logic [2:0][15:0] load_val;
    logic [2:0] load_req;
    logic [7:0] dout;
    logic doe;
  } pitp_port_st_t;

  pitp_port_st_t st;
  pitp_port_st_t next_st;
  pitp_bus_t bus_pin;
  logic [2:0][15:0] cnt;
  logic wr_edge;
  logic rd_end;
  logic rd_act;
  logic [1:0] wch;
  logic [1:0] rch;
  logic [1:0] sc;
  logic [7:0] wd;
  logic [15:0] rval;
  logic rd_msb;

  assign bus_pin = {cs_n, rd_n, wr_n, port_addr_high, port_addr_low,
                    data_in};

  // ==========================================================================
  // decode of synchronised strobes
  assign wd = st.s3.data;
  assign sc = wd[PITP_SC_HI:PITP_SC_LO];
  assign wch = pitp_chan(st.s3.addr);
  assign rch = pitp_chan(st.s2.addr);
  // write completes on the strobe's rising edge, select still low
  assign wr_edge = st.s2.wr_n & ~st.s3.wr_n & ~st.s3.cs_n;
  assign rd_end = st.s2.rd_n & ~st.s3.rd_n & ~st.s3.cs_n &
                  (st.s3.addr != PITP_ADDR_CTRL);
  assign rd_act = ~st.s2.cs_n & ~st.s2.rd_n & st.s2.wr_n &
                  (st.s2.addr != PITP_ADDR_CTRL);
  assign rval = st.latched[rch] ? st.latch_val[rch] : cnt[rch];
  assign rd_msb = (st.cfg[rch].rl == PITP_RL_MSB) ||
                  (st.cfg[rch].rl == PITP_RL_BOTH &&
                   st.rd_ph[rch] == PITP_PH_MSB);

  always_comb begin
    next_st = st;
    next_st.s1 = bus_pin;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.load_req = '0;
    // ========================================================================
    // writes
    if (wr_edge && st.s3.addr == PITP_ADDR_CTRL) begin
      if (sc != PITP_SC_ILLEGAL) begin
        if (wd[PITP_RL_HI:PITP_RL_LO] == PITP_RL_LATCH) begin
          next_st.latched[sc] = 1'b1;
          next_st.latch_val[sc] = cnt[sc];
        end else begin
          next_st.cfg[sc] = wd[PITP_RL_HI:PITP_BCD_BIT];
          next_st.wr_ph[sc] = PITP_PH_LSB;
          next_st.rd_ph[sc] = PITP_PH_LSB;
          next_st.latched[sc] = 1'b0;
        end
      end
    end else if (wr_edge) begin
      case (st.cfg[wch].rl)
        PITP_RL_LSB: begin
          next_st.load_val[wch] = {PITP_BYTE_ZERO, wd};
          next_st.load_req[wch] = 1'b1;
        end
        PITP_RL_MSB: begin
          next_st.load_val[wch] = {wd, PITP_BYTE_ZERO};
          next_st.load_req[wch] = 1'b1;
        end
        PITP_RL_BOTH: begin
          if (st.wr_ph[wch] == PITP_PH_LSB) begin
            next_st.lsb_hold[wch] = wd;
            next_st.wr_ph[wch] = PITP_PH_MSB;
          end else begin
            next_st.load_val[wch] = {wd, st.lsb_hold[wch]};
            next_st.load_req[wch] = 1'b1;
            next_st.wr_ph[wch] = PITP_PH_LSB;
          end
        end
        default: begin
          // unprogrammed channel ignores count bytes
        end
      endcase
    end
    // ========================================================================
    // reads
    next_st.doe = rd_act;
    next_st.dout = rd_msb ? rval[15:8] : rval[7:0];
    if (rd_end) begin
      if (st.cfg[rch].rl == PITP_RL_BOTH &&
          st.rd_ph[pitp_chan(st.s3.addr)] == PITP_PH_LSB) begin
        next_st.rd_ph[pitp_chan(st.s3.addr)] = PITP_PH_MSB;
      end else begin
        next_st.rd_ph[pitp_chan(st.s3.addr)] = PITP_PH_LSB;
        next_st.latched[pitp_chan(st.s3.addr)] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.s1 <= PITP_BUS_IDLE;
      st.s2 <= PITP_BUS_IDLE;
      st.s3 <= PITP_BUS_IDLE;
      st.cfg <= {PITP_NUM_CH{PITP_CFG_RST}};
    end else begin
      st <= next_st;
    end
  end

  assign data_out = st.dout;
  assign data_oe = st.doe;

  // ==========================================================================
  // counters, select does not reach them
  for (genvar i = 0; i < PITP_NUM_CH; i++) begin : g_ch
    pitp_counter u_cnt (
      .clk(clk),
      .rst_n(rst_n),
      .tclk(tmr_clk[i]),
      .gate(tmr_gate[i]),
      .load_req(st.load_req[i]),
      .load_val(st.load_val[i]),
      .bcd(st.cfg[i].bcd),
      .mode(st.cfg[i].mode),
      .count(cnt[i]),
      .out(tmr_out[i])
    );
  end

  // ==========================================================================
  // checks
  chk_cs_float: assert property (@(posedge clk) disable iff (!rst_n)
    st.s2.cs_n |=> !data_oe)
    else $error("data driven while deselected");

  chk_ctrl_noread: assert property (@(posedge clk) disable iff (!rst_n)
    st.s2.addr == PITP_ADDR_CTRL |=> !data_oe)
    else $error("control word address drove the bus");

  chk_idle_float: assert property (@(posedge clk) disable iff (!rst_n)
    !st.s2.cs_n && st.s2.rd_n && st.s2.wr_n |=> !data_oe)
    else $error("idle strobes drove the bus");

  chk_read_drive: assert property (@(posedge clk) disable iff (!rst_n)
    rd_act |=> data_oe && data_out == $past(next_st.dout))
    else $error("read did not present counter data");

  chk_ctrl_store: assert property (@(posedge clk) disable iff (!rst_n)
    wr_edge && st.s3.addr == PITP_ADDR_CTRL && sc != PITP_SC_ILLEGAL &&
      wd[PITP_RL_HI:PITP_RL_LO] != PITP_RL_LATCH
      |=> st.cfg[$past(sc)] == $past(wd[PITP_RL_HI:PITP_BCD_BIT]))
    else $error("control word not stored");

  chk_sc_illegal: assert property (@(posedge clk) disable iff (!rst_n)
    wr_edge && st.s3.addr == PITP_ADDR_CTRL && sc == PITP_SC_ILLEGAL
      |=> $stable(st.cfg) && $stable(st.latched))
    else $error("illegal counter select took effect");

  chk_latch_cmd: assert property (@(posedge clk) disable iff (!rst_n)
    wr_edge && st.s3.addr == PITP_ADDR_CTRL && sc != PITP_SC_ILLEGAL &&
      wd[PITP_RL_HI:PITP_RL_LO] == PITP_RL_LATCH
      |=> st.latched[$past(sc)] && $stable(st.cfg))
    else $error("latch command not taken");

  chk_lsb_load: assert property (@(posedge clk) disable iff (!rst_n)
    wr_edge && st.s3.addr != PITP_ADDR_CTRL &&
      st.cfg[wch].rl == PITP_RL_LSB |=> st.load_req[$past(wch)] &&
      st.load_val[$past(wch)] == {PITP_BYTE_ZERO, $past(wd)})
    else $error("single lsb byte not loaded");

  chk_load_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    st.load_req != 3'h0 |=> st.load_req == 3'h0)
    else $error("load request longer than one cycle");

  cov_ctrl_write: cover property (@(posedge clk) disable iff (!rst_n)
    wr_edge && st.s3.addr == PITP_ADDR_CTRL);

  cov_two_byte: cover property (@(posedge clk) disable iff (!rst_n)
    wr_edge && st.cfg[wch].rl == PITP_RL_BOTH &&
    st.wr_ph[wch] == PITP_PH_MSB);

  cov_read: cover property (@(posedge clk) disable iff (!rst_n)
    rd_act ##1 data_oe);

endmodule

/* File: verification/pitp_cpu_model.sv */
/*
  behavioural cpu on the parallel port bus of the interval timer.
  assumes calls start just after a rising clk edge; resolves the data bus.
*/
`timescale 1ns/1ps
module pitp_cpu_model
  import pitp_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic [7:0] data_out, // device data pins
  input wire logic data_oe, // device drives data
  output logic cs_n, // select, active low
  output logic rd_n, // read strobe, active low
  output logic wr_n, // write strobe, active low
  output logic port_addr_low, // address bit 0
  output logic port_addr_high, // address bit 1
  output logic [7:0] data_in // resolved data bus
);
  pitp_bus_t bus = PITP_BUS_IDLE;
  logic drv = 1'b0;
  logic [7:0] last = 8'h00;

  assign cs_n = bus.cs_n;
  assign rd_n = bus.rd_n;
  assign wr_n = bus.wr_n;
  assign port_addr_low = bus.addr[0];
  assign port_addr_high = bus.addr[1];
  // undriven bus shows a changing pattern
  assign data_in = data_oe ? data_out : (drv ? bus.data : ~last);

  always @(posedge clk) begin
    last <= data_in;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask

  // data and address held around the whole strobe
  task automatic bus_wr(input logic sel_n, input logic [1:0] a,
                        input logic [7:0] d);
    bus.cs_n <= sel_n;
    bus.addr <= a;
    bus.data <= d;
    drv <= 1'b1;
    wait_clk(3);
    bus.wr_n <= 1'b0;
    wait_clk(4);
    bus.wr_n <= 1'b1;
    wait_clk(4);
    bus.cs_n <= 1'b1;
    drv <= 1'b0;
    wait_clk(1);
  endtask

  task automatic bus_rd(input logic sel_n, input logic [1:0] a,
                        output logic [7:0] d, output logic oe);
    bus.cs_n <= sel_n;
    bus.addr <= a;
    wait_clk(3);
    bus.rd_n <= 1'b0;
    wait_clk(6);
    d = data_out;
    oe = data_oe;
    bus.rd_n <= 1'b1;
    wait_clk(5);
    bus.cs_n <= 1'b1;
    wait_clk(1);
  endtask
endmodule

/* File: verification/testbench.sv */
/*
  self-checking bench for the interval timer host port.
  assumes the cpu model drives the port; counter pins are driven here.
*/
`timescale 1ns/1ps
module testbench;
  import pitp_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cs_n, rd_n, wr_n, port_addr_low, port_addr_high, data_oe;
  logic [7:0] data_in, data_out;
  logic [2:0] tmr_clk = 3'h0;
  logic [2:0] tmr_gate = 3'h0;
  logic [2:0] tmr_out;
  int mismatches = 0;
  int total_checks = 0;

  pitp_host_port u_dut (.clk(clk), .rst_n(rst_n), .cs_n(cs_n),
    .rd_n(rd_n), .wr_n(wr_n), .port_addr_low(port_addr_low),
    .port_addr_high(port_addr_high), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .tmr_clk(tmr_clk),
    .tmr_gate(tmr_gate), .tmr_out(tmr_out));
  pitp_cpu_model u_cpu (.clk(clk), .data_out(data_out),
    .data_oe(data_oe), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .port_addr_low(port_addr_low), .port_addr_high(port_addr_high),
    .data_in(data_in));

  always #2.5 clk = ~clk;

  // ==========================================================================
  // helpers
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] exp, input logic [7:0] act);
    total_checks++;
    if (act !== exp) begin
      mismatches++;
      $display("mismatch at %0t exp %h got %h", $time, exp, act);
    end
  endtask

  task automatic rd_chk(input logic sel_n, input logic [1:0] a,
                        input logic oe_exp, input logic [7:0] exp);
    logic [7:0] d;
    logic oe;
    u_cpu.bus_rd(sel_n, a, d, oe);
    chk({7'h00, oe_exp}, {7'h00, oe});
    if (oe_exp) begin
      chk(exp, d);
    end
  endtask

  task automatic tick(input int ch);
    tmr_clk[ch] <= 1'b1;
    repeat (4) @(posedge clk);
    tmr_clk[ch] <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_float();
    rd_chk(1'b1, 2'h0, 1'b0, 8'h00);
    rd_chk(1'b0, 2'h3, 1'b0, 8'h00);
    u_cpu.bus.cs_n <= 1'b0;
    repeat (6) @(posedge clk);
    chk(8'h00, {7'h00, data_oe});
    u_cpu.bus.cs_n <= 1'b1;
    @(posedge clk);
    $display("test float done");
  endtask

  task automatic t_load16();
    u_cpu.bus_wr(1'b0, 2'h3, 8'h30);
    u_cpu.bus_wr(1'b0, 2'h0, 8'h34);
    u_cpu.bus_wr(1'b0, 2'h0, 8'h12);
    tick(0);
    rd_chk(1'b0, 2'h0, 1'b1, 8'h34);
    rd_chk(1'b0, 2'h0, 1'b1, 8'h12);
    u_cpu.bus_wr(1'b1, 2'h3, 8'h10);
    rd_chk(1'b0, 2'h0, 1'b1, 8'h34);
    rd_chk(1'b0, 2'h0, 1'b1, 8'h12);
    $display("test load16 done");
  endtask

  task automatic t_single();
    u_cpu.bus_wr(1'b0, 2'h3, 8'h50);
    u_cpu.bus_wr(1'b0, 2'h1, 8'h7A);
    tick(1);
    u_cpu.bus_wr(1'b0, 2'h3, 8'hA0);
    u_cpu.bus_wr(1'b0, 2'h2, 8'h5B);
    tick(2);
    rd_chk(1'b0, 2'h1, 1'b1, 8'h7A);
    rd_chk(1'b0, 2'h2, 1'b1, 8'h5B);
    $display("test single done");
  endtask

  task automatic t_count();
    tmr_gate[1] <= 1'b1;
    repeat (3) tick(1);
    rd_chk(1'b0, 2'h1, 1'b1, 8'h77);
    rd_chk(1'b0, 2'h0, 1'b1, 8'h34);
    rd_chk(1'b0, 2'h0, 1'b1, 8'h12);
    u_cpu.bus_wr(1'b0, 2'h3, 8'h40);
    repeat (2) tick(1);
    rd_chk(1'b0, 2'h1, 1'b1, 8'h77);
    rd_chk(1'b0, 2'h1, 1'b1, 8'h75);
    $display("test count done");
  endtask

  task automatic t_bcd();
    u_cpu.bus_wr(1'b0, 2'h3, 8'h91);
    u_cpu.bus_wr(1'b0, 2'h2, 8'h10);
    tick(2);
    tmr_gate[2] <= 1'b1;
    tick(2);
    rd_chk(1'b0, 2'h2, 1'b1, 8'h09);
    $display("test bcd done");
  endtask

  // rate mode on channel 0: reload at one, output dips low
  task automatic t_rate();
    u_cpu.bus_wr(1'b0, 2'h3, 8'h14);
    u_cpu.bus_wr(1'b0, 2'h0, 8'h02);
    tick(0);
    chk(8'h01, {7'h00, tmr_out[0]});
    tmr_gate[0] <= 1'b1;
    tick(0);
    chk(8'h01, {7'h00, tmr_out[0]});
    tick(0);
    chk(8'h00, {7'h00, tmr_out[0]});
    rd_chk(1'b0, 2'h0, 1'b1, 8'h02);
    $display("test rate done");
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_float();
    t_load16();
    t_single();
    t_count();
    t_bcd();
    t_rate();
    test_done();
  end

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    test_done();
  end
endmodule
